// ===== pkg/dic_consts.svh
// timing counts, field codes and unit scales of the input conditioning block
// assumes the 25 MHz system clock
`ifndef DIC_CONSTS_SVH
`define DIC_CONSTS_SVH
`define DIC_CLK_NS      40
`define DIC_MS_NS       1000000
`define DIC_SEC_NS      1000000000
`define DIC_TENTH_MS    7'h64
`define DIC_MODE_3W2    2'h3
`define DIC_RES_HUNDR   2'h1
`define DIC_STEP_HUNDR  24'h00000a
`define DIC_STEP_THOU   24'h000001
`define DIC_CURVE_ONE   4'h1
`define DIC_CURVE_TWO   4'h2
`define DIC_FILT_MS     4'ha
`endif

// ===== pkg/dic_pkg.sv
// types shared by the input conditioning block
// assumes nothing of its surroundings
package dic_pkg;
  typedef enum logic {RUN_STOP, RUN_GO} dic_run_e;
  // two-point curve: inputs unsigned, settings signed in 0.01 %
  typedef struct packed {
    logic        [15:0] minIn;
    logic signed [15:0] minSet;
    logic        [15:0] maxIn;
    logic signed [15:0] maxSet;
  } dic_curve_s;
  typedef struct packed {
    logic        [31:0] filt;
    logic signed [15:0] out;
  } dic_map_s;
  typedef struct packed {
    logic        out;
    logic [6:0]  msCnt;
    logic [15:0] tenthCnt;
  } dic_dly_s;
  typedef struct packed {
    dic_run_e    run;
    logic        forward_run;
    logic        reverse_run;
    logic [4:0]  act;
    logic        trigPrev;
    logic        pulsePrev;
    logic [23:0] freq;
    logic [31:0] acc;
    logic [31:0] msCnt;
    logic        msTick;
    logic [6:0]  gateCnt;
    logic [15:0] edgeCnt;
    logic [15:0] pulseFreq;
  } dic_top_s;
endpackage

// ===== logic/dic_input_delay.sv
// status-change delay for one digital input, in 0.1 s steps
// assumes a one-cycle msTick every millisecond
`timescale 1ns/10ps
`default_nettype none
`include "dic_consts.svh"
module dic_input_delay (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // timing
  input  wire logic        msTick,
  input  wire logic [15:0] delayTenths,
  // level in and out
  input  wire logic        din,
  output logic             dout
);
  dic_pkg::dic_dly_s st_r;
  dic_pkg::dic_dly_s st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (din == st_r.out) begin
      st_nxt.msCnt    = 7'h00;
      st_nxt.tenthCnt = 16'h0000;
    end else if (delayTenths == 16'h0000) begin
      st_nxt.out = din;
    end else if (msTick) begin
      st_nxt.msCnt = st_r.msCnt + 7'h01;
      if (st_r.msCnt == `DIC_TENTH_MS - 7'h01) begin
        st_nxt.msCnt    = 7'h00;
        st_nxt.tenthCnt = st_r.tenthCnt + 16'h0001;
        if (st_r.tenthCnt + 16'h0001 >= delayTenths) begin
          st_nxt.out = din;
        end
      end
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign dout = st_r.out;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  nodelay_pass_a: assert property ((delayTenths == 16'h0000) |=> (dout == $past(din)))
    else $error("zero delay did not pass the input");
  steady_hold_a: assert property ((din == dout) |=> $stable(dout))
    else $error("delayed output changed without input change");
endmodule
`default_nettype wire

// ===== logic/dic_curve_map.sv
// low-pass filter then two-point curve mapping of one sampled input
// assumes msTick once per millisecond, filter time in 0.01 s
`timescale 1ns/10ps
`default_nettype none
`include "dic_consts.svh"
module dic_curve_map (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // sample and settings
  input  wire logic               msTick,
  input  wire logic [15:0]        sampleIn,
  input  wire logic [9:0]         filterTime,
  input  wire dic_pkg::dic_curve_s cv,
  input  wire logic               belowZero,
  // mapped setting
  output logic signed [15:0]      setting
);
  dic_pkg::dic_map_s st_r;
  dic_pkg::dic_map_s st_nxt;
  logic        [15:0] x;
  logic        [13:0] tms;
  logic signed [33:0] diff;
  logic signed [33:0] prod;
  logic signed [33:0] span;
  assign x   = st_r.filt[31:16];
  assign tms = 14'({filterTime, 3'h0}) + 14'({filterTime, 1'h0});
  always_comb begin
    st_nxt = st_r;
    diff   = $signed({2'h0, sampleIn, 16'h0000}) - $signed({2'h0, st_r.filt});
    prod   = $signed({18'h0, 16'(x - cv.minIn)})
           * (34'($signed(cv.maxSet)) - 34'($signed(cv.minSet)));
    span   = $signed({18'h0, 16'(cv.maxIn - cv.minIn)});
    if (filterTime == 10'h000) begin
      st_nxt.filt = {sampleIn, 16'h0000};
    end else if (msTick) begin
      st_nxt.filt = st_r.filt + 32'(diff / $signed({20'h0, tms}));
    end
    if (x >= cv.maxIn) begin
      st_nxt.out = cv.maxSet;
    end else if (x < cv.minIn) begin
      st_nxt.out = belowZero ? 16'sh0000 : cv.minSet;
    end else begin
      st_nxt.out = 16'(34'($signed(cv.minSet)) + prod / span);
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign setting = st_r.out;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  above_max_a: assert property ((x >= cv.maxIn) |=> (setting == $past(cv.maxSet)))
    else $error("input above maximum not clamped");
  below_zero_a: assert property ((x < cv.minIn && x < cv.maxIn && belowZero) |=> (setting == 16'sh0000))
    else $error("input below minimum not zeroed");
  filter_off_a: assert property ((filterTime == 10'h000) |=> (x == $past(sampleIn)))
    else $error("zero filter time did not pass the sample");
endmodule
`default_nettype wire

// ===== logic/dic_input_top.sv
// input terminal conditioning: three-wire mode 2 run decode, up/down
// frequency ramp, analog and pulse curve mapping, input delay and polarity
// assumes inputs synchronous to sys_clk; diRaw high means closed to common
`timescale 1ns/10ps
`default_nettype none
`include "dic_consts.svh"
// Summary of operation
// - command mode 3 uses input three enable, one trigger, two direction
// - start only while enable active and trigger input becomes active
// - direction inactive gives forward, active gives reverse
// - enable going inactive stops at once; operator keeps it active
// - run state follows the latest input transitions only
// - up/down terminals ramp the frequency reference at a set rate
// - rate unit follows resolution: 0.001 or 0.01 Hz per second
// - analog inputs map linearly between two curve points
// - input above maximum point uses the maximum setting
// - below minimum uses minimum setting or zero per selector bit
// - current input: one milliampere equals half a volt
// - each analog input has a programmable filter time
// - pulse input only on input five, mapped like analog inputs
// - curve for each analog input chosen by a selection digit
// - inputs one and two have a programmable change delay
// - per-input polarity: 0 high-level valid, 1 low-level valid
// - high-level valid: active while closed to common return
module dic_input_top #(
  parameter int MS_CYCLES  = `DIC_MS_NS / `DIC_CLK_NS,
  parameter int SEC_CYCLES = `DIC_SEC_NS / `DIC_CLK_NS
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // digital terminals, high when closed to common return
  input  wire logic [4:0]          diRaw,
  // terminal settings
  input  wire logic [1:0]          terminalCommandMode,
  input  wire logic [4:0]          inputPolarity,
  input  wire logic [15:0]         delayOne,
  input  wire logic [15:0]         delayTwo,
  // up/down frequency settings
  input  wire logic                upReq,
  input  wire logic                downReq,
  input  wire logic [1:0]          frequencyResolution,
  input  wire logic [15:0]         updownRate,
  input  wire logic [23:0]         freqLow,
  input  wire logic [23:0]         freqHigh,
  // analog and pulse settings
  input  wire logic [15:0]         aiOneSample,
  input  wire logic [15:0]         aiTwoSample,
  input  wire logic [1:0]          aiCurrentMode,
  input  wire dic_pkg::dic_curve_s curveOne,
  input  wire dic_pkg::dic_curve_s curveTwo,
  input  wire dic_pkg::dic_curve_s curvePulse,
  input  wire logic [3:0]          curveSelOne,
  input  wire logic [3:0]          curveSelTwo,
  input  wire logic [2:0]          belowMinimumZero,
  input  wire logic [9:0]          filterOne,
  input  wire logic [9:0]          filterTwo,
  input  wire logic [9:0]          filterPulse,
  // run command
  output logic                     forwardRun,
  output logic                     reverseRun,
  // conditioned values
  output logic [4:0]               diActive,
  output logic [23:0]              freqReference,
  output logic [15:0]              pulseFreq,
  output logic signed [15:0]       settingOne,
  output logic signed [15:0]       settingTwo,
  output logic signed [15:0]       settingPulse
);

  // ****************************************
  // helpers
  // ****************************************
  // current mode halves the reading: mA code to volt code
  function automatic logic [15:0] scaleAi(input logic isCurrent, input logic [15:0] raw);
    scaleAi = isCurrent ? {1'b0, raw[15:1]} : raw;
  endfunction

  function automatic dic_pkg::dic_curve_s pickCurve(input logic [3:0] sel,
                                                     input dic_pkg::dic_curve_s own);
    if (sel == `DIC_CURVE_ONE) begin
      pickCurve = curveOne;
    end else if (sel == `DIC_CURVE_TWO) begin
      pickCurve = curveTwo;
    end else begin
      pickCurve = own;
    end
  endfunction

  function automatic logic [23:0] sat(input logic [23:0] v, input logic [23:0] lo,
                                      input logic [23:0] hi);
    if (v > hi) begin
      sat = hi;
    end else if (v < lo) begin
      sat = lo;
    end else begin
      sat = v;
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  dic_pkg::dic_top_s st_r;
  dic_pkg::dic_top_s st_nxt;
  logic [4:0]  polAct;
  logic        dlyOne;
  logic        dlyTwo;
  logic        runEnable;
  logic        trigRise;
  logic        dirSel;
  logic [15:0] rate;
  logic [23:0] step;
  logic [23:0] upVal;
  logic [23:0] dnVal;
  logic [31:0] accSum;

  // closed is active at high valid
  // open is active at low valid
  assign polAct = diRaw ^ inputPolarity;

  // ****************************************
  // input delay
  // ****************************************
  dic_input_delay uDelayOne (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .msTick      (st_r.msTick),
    .delayTenths (delayOne),
    .din         (polAct[0]),
    .dout        (dlyOne)
  );

  dic_input_delay uDelayTwo (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .msTick      (st_r.msTick),
    .delayTenths (delayTwo),
    .din         (polAct[1]),
    .dout        (dlyTwo)
  );

  // ****************************************
  // run decode
  // ****************************************
  // terminal roles in mode 3
  assign runEnable = st_r.act[2];
  assign trigRise  = st_r.act[0] & ~st_r.trigPrev;
  assign dirSel    = st_r.act[1];

  // ****************************************
  // up/down ramp
  // ****************************************
  // step size from resolution
  assign step   = (frequencyResolution == `DIC_RES_HUNDR) ? `DIC_STEP_HUNDR : `DIC_STEP_THOU;
  assign rate   = (updownRate == 16'h0000) ? 16'h0001 : updownRate;
  assign accSum = st_r.acc + {16'h0000, rate};
  assign upVal  = (st_r.freq > 24'hffffff - step) ? 24'hffffff : st_r.freq + step;
  assign dnVal  = (st_r.freq < step) ? 24'h000000 : st_r.freq - step;

  always_comb begin
    st_nxt = st_r;
    // millisecond and 100 ms time base
    st_nxt.msTick = 1'b0;
    st_nxt.msCnt  = st_r.msCnt + 32'h1;
    if (st_r.msCnt >= 32'(MS_CYCLES - 1)) begin
      st_nxt.msCnt  = 32'h0;
      st_nxt.msTick = 1'b1;
    end
    // only inputs one and two delayed
    st_nxt.act      = {polAct[4:2], dlyTwo, dlyOne};
    st_nxt.trigPrev = st_r.act[0];
    if (terminalCommandMode != `DIC_MODE_3W2 || !runEnable) begin
      st_nxt.run = dic_pkg::RUN_STOP;
    end else if (trigRise) begin
      st_nxt.run = dic_pkg::RUN_GO;
    end
    st_nxt.forward_run = (st_nxt.run == dic_pkg::RUN_GO) & ~dirSel;
    st_nxt.reverse_run = (st_nxt.run == dic_pkg::RUN_GO) & dirSel;
    if (upReq ^ downReq) begin
      st_nxt.acc = accSum;
      if (accSum >= 32'(SEC_CYCLES)) begin
        st_nxt.acc  = accSum - 32'(SEC_CYCLES);
        st_nxt.freq = upReq ? upVal : dnVal;
      end
    end else begin
      st_nxt.acc = 32'h0;
    end
    st_nxt.freq = sat(st_nxt.freq, freqLow, freqHigh);
    st_nxt.pulsePrev = st_r.act[4];
    if (st_r.act[4] && !st_r.pulsePrev) begin
      st_nxt.edgeCnt = st_r.edgeCnt + 16'h0001;
    end
    if (st_r.msTick) begin
      st_nxt.gateCnt = st_r.gateCnt + 7'h01;
      if (st_r.gateCnt == `DIC_TENTH_MS - 7'h01) begin
        st_nxt.gateCnt   = 7'h00;
        st_nxt.pulseFreq = st_nxt.edgeCnt;
        st_nxt.edgeCnt   = 16'h0000;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // analog and pulse mapping
  // ****************************************
  // current to voltage scaling
  dic_curve_map uMapOne (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .msTick     (st_r.msTick),
    .sampleIn   (scaleAi(aiCurrentMode[0], aiOneSample)),
    .filterTime (filterOne),
    .cv         (pickCurve(curveSelOne, curveOne)),
    .belowZero  (belowMinimumZero[0]),
    .setting    (settingOne)
  );

  dic_curve_map uMapTwo (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .msTick     (st_r.msTick),
    .sampleIn   (scaleAi(aiCurrentMode[1], aiTwoSample)),
    .filterTime (filterTwo),
    .cv         (pickCurve(curveSelTwo, curveTwo)),
    .belowZero  (belowMinimumZero[1]),
    .setting    (settingTwo)
  );

  dic_curve_map uMapPulse (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .msTick     (st_r.msTick),
    .sampleIn   (st_r.pulseFreq),
    .filterTime (filterPulse),
    .cv         (curvePulse),
    .belowZero  (belowMinimumZero[2]),
    .setting    (settingPulse)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign forwardRun    = st_r.forward_run;
  assign reverseRun    = st_r.reverse_run;
  assign diActive      = st_r.act;
  assign freqReference = st_r.freq;
  assign pulseFreq     = st_r.pulseFreq;

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  enable_stop_a: assert property (!runEnable |=> !forwardRun && !reverseRun)
    else $error("run continued after enable loss");
  dir_excl_a: assert property (!(forwardRun && reverseRun))
    else $error("forward and reverse both active");
  start_cause_a: assert property ($rose(forwardRun || reverseRun) |-> $past(trigRise && runEnable))
    else $error("run started without enable and trigger");
  mode_gate_a: assert property ((terminalCommandMode != `DIC_MODE_3W2) |=> !forwardRun && !reverseRun)
    else $error("run active outside mode 3");
  freq_limit_a: assert property ((freqLow <= freqHigh)
                                 |=> (freqReference >= $past(freqLow))
                                     && (freqReference <= $past(freqHigh)))
    else $error("frequency reference outside limits");
  freq_hold_a: assert property ((upReq == downReq) && $stable(freqLow) && $stable(freqHigh)
                                && freqReference >= freqLow && freqReference <= freqHigh
                                |=> $stable(freqReference))
    else $error("frequency reference moved without up or down");
  polarity_a: assert property (1'b1 |=>
                               diActive[4:2] == $past(diRaw[4:2] ^ inputPolarity[4:2]))
    else $error("polarity of undelayed inputs wrong");
endmodule
`default_nettype wire

// ===== testbench/dic_field_model.sv
// field side model: switches, pushbuttons and a pulse source on the terminals
// assumes the bench sets switch states and pulse half period at the falling edge
`timescale 1ns/10ps
`default_nettype none
module dic_field_model (
  // clock
  input  wire logic       sys_clk,
  // switch states and pulse half period in clock cycles, zero for none
  input  wire logic [3:0] closedIn,
  input  wire logic [7:0] pulseHalf,
  // terminal levels, high when closed to common return
  output logic      [4:0] diRaw
);
  // ****************
  // pulse source
  // ****************
  logic [7:0] halfCnt;
  logic       pulseLvl;
  initial begin
    halfCnt  = 8'h00;
    pulseLvl = 1'b0;
  end
  always @(negedge sys_clk) begin
    if (pulseHalf == 8'h00) begin
      halfCnt  <= 8'h00;
      pulseLvl <= 1'b0;
    end else if (halfCnt == pulseHalf - 8'h01) begin
      halfCnt  <= 8'h00;
      pulseLvl <= ~pulseLvl;
    end else begin
      halfCnt <= halfCnt + 8'h01;
    end
  end
  assign diRaw = {pulseLvl, closedIn};
endmodule
`default_nettype wire

// ===== testbench/dic_input_top_tb.sv
// self-checking bench of the input terminal conditioning block
// assumes shortened millisecond and second counts of 4 and 100 cycles
`timescale 1ns/10ps
`default_nettype none
module dic_input_top_tb;
  logic                sys_clk;
  logic                reset;
  logic [3:0]          closed;
  logic [7:0]          pulseHalf;
  logic [4:0]          diRaw;
  logic [1:0]          mode;
  logic [4:0]          pol;
  logic [15:0]         dlyOne;
  logic [15:0]         dlyTwo;
  logic                upReq;
  logic                downReq;
  logic [1:0]          fRes;
  logic [15:0]         rate;
  logic [15:0]         aiOne;
  logic [15:0]         aiTwo;
  logic [1:0]          curMode;
  dic_pkg::dic_curve_s cvOne;
  dic_pkg::dic_curve_s cvTwo;
  dic_pkg::dic_curve_s cvPulse;
  logic [3:0]          selOne;
  logic [3:0]          selTwo;
  logic [2:0]          belowZero;
  logic [9:0]          filtOne;
  logic [23:0]         fLo;
  logic [23:0]         fHi;
  logic                forward_run;
  logic                reverse_run;
  logic [4:0]          act;
  logic [23:0]         fRef;
  logic [15:0]         pFreq;
  logic signed [15:0]  setOne;
  logic signed [15:0]  setTwo;
  logic signed [15:0]  setPulse;
  int                  badCount;
  int                  nChecks;
  int                  f0;
  int                  smp[7]  = '{50, 50, 1000, 500, 1000, 100, 900};
  int                  expv[7] = '{-5000, 0, 10000, 2500, 2500, -5000, 10000};
  bit [6:0]            blw     = 7'h02;
  bit [6:0]            cur     = 7'h10;

  dic_field_model u_dic_field_model (
    .sys_clk  (sys_clk),
    .closedIn (closed),
    .pulseHalf(pulseHalf),
    .diRaw    (diRaw)
  );
  dic_input_top #(.MS_CYCLES(4), .SEC_CYCLES(100)) u_dic_input_top (
    .sys_clk(sys_clk), .reset(reset), .diRaw(diRaw),
    .terminalCommandMode(mode), .inputPolarity(pol),
    .delayOne(dlyOne), .delayTwo(dlyTwo), .upReq(upReq), .downReq(downReq),
    .frequencyResolution(fRes), .updownRate(rate),
    .freqLow(fLo), .freqHigh(fHi),
    .aiOneSample(aiOne), .aiTwoSample(aiTwo), .aiCurrentMode(curMode),
    .curveOne(cvOne), .curveTwo(cvTwo), .curvePulse(cvPulse),
    .curveSelOne(selOne), .curveSelTwo(selTwo), .belowMinimumZero(belowZero),
    .filterOne(filtOne), .filterTwo(10'h000), .filterPulse(10'h000),
    .forwardRun(forward_run), .reverseRun(reverse_run), .diActive(act), .freqReference(fRef),
    .pulseFreq(pFreq), .settingOne(setOne), .settingTwo(setTwo),
    .settingPulse(setPulse)
  );

  // ****************
  // shared tasks
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("BAD %s expected %0d seen %0d", name, $signed(exp), $signed(seen));
    end
  endtask
  task automatic rng(input string name, input logic signed [31:0] v, input int lo,
                     input int hi);
    chk(name, {31'h0, (v >= lo) && (v <= hi)}, 32'h1);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    badCount++;
    $display("BAD watchdog expected finish seen hang");
    tally_and_finish;
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    badCount = 0;
    nChecks = 0;
    reset = 1'b1;
    closed = 4'h0;
    pulseHalf = 8'h00;
    mode = 2'h0;
    pol = 5'h00;
    dlyOne = 16'h0000;
    dlyTwo = 16'h0000;
    upReq = 1'b0;
    downReq = 1'b0;
    fRes = 2'h1;
    rate = 16'h0032;
    aiOne = 16'h0000;
    aiTwo = 16'h0000;
    curMode = 2'h0;
    cvOne = '{16'h0064, -16'sh1388, 16'h0384, 16'sh2710};
    cvTwo = '{16'h0000, 16'sh0000, 16'h03e8, 16'sh2710};
    cvPulse = '{16'h0000, 16'sh0000, 16'h0064, 16'sh2710};
    selOne = 4'h1;
    selTwo = 4'h1;
    belowZero = 3'h0;
    filtOne = 10'h000;
    fLo = 24'h0003e8;
    fHi = 24'h0007d0;
    cyc(8);
    chk("act in reset", act, 0);
    reset = 1'b0;
    cyc(1);
    chk("ref clamp", fRef, 1000);
    for (int i = 0; i < 4; i++) begin
      pol = i[0] ? 5'h1f : 5'h00;
      closed = i[1] ? 4'ha : 4'h5;
      cyc(3);
      chk("polarity", act, {1'b0, closed} ^ pol);
    end
    pol = 5'h00;
    closed = 4'h0;
    cyc(3);
    dlyOne = 16'h0001;
    dlyTwo = 16'h0002;
    closed = 4'hb;
    cyc(3);
    chk("no delay", act, 5'h08);
    cyc(250);
    chk("delay early", act, 5'h08);
    cyc(200);
    chk("delay one", act, 5'h09);
    cyc(400);
    chk("delay two", act, 5'h0b);
    dlyOne = 16'h0000;
    dlyTwo = 16'h0000;
    cyc(2);
    closed = 4'h0;
    cyc(5);
    mode = 2'h3;
    closed = 4'h4;
    cyc(3);
    closed = 4'h5;
    cyc(3);
    chk("start", {forward_run, reverse_run}, 2'b10);
    closed = 4'h7;
    cyc(3);
    chk("reverse", {forward_run, reverse_run}, 2'b01);
    closed = 4'h5;
    cyc(3);
    chk("forward again", {forward_run, reverse_run}, 2'b10);
    closed = 4'h1;
    cyc(2);
    chk("stop", {forward_run, reverse_run}, 2'b00);
    closed = 4'h5;
    cyc(4);
    chk("held trigger", {forward_run, reverse_run}, 2'b00);
    closed = 4'h4;
    cyc(3);
    closed = 4'h3;
    cyc(4);
    chk("no enable", {forward_run, reverse_run}, 2'b00);
    closed = 4'h4;
    cyc(3);
    closed = 4'h7;
    cyc(3);
    chk("start reverse", {forward_run, reverse_run}, 2'b01);
    mode = 2'h2;
    cyc(3);
    chk("other mode", {forward_run, reverse_run}, 2'b00);
    mode = 2'h0;
    closed = 4'h0;
    upReq = 1'b1;
    cyc(20);
    upReq = 1'b0;
    cyc(2);
    rng("up rate", fRef, 1090, 1110);
    fRes = 2'h2;
    f0 = fRef;
    upReq = 1'b1;
    cyc(20);
    upReq = 1'b0;
    cyc(2);
    rng("fine rate", fRef - f0, 9, 11);
    fRes = 2'h1;
    rate = 16'h0063;
    upReq = 1'b1;
    cyc(200);
    chk("upper limit", fRef, 2000);
    upReq = 1'b0;
    downReq = 1'b1;
    cyc(200);
    chk("lower limit", fRef, 1000);
    fLo = 24'h0004b0;
    cyc(2);
    chk("raised limit", fRef, 1200);
    downReq = 1'b0;
    for (int i = 0; i < 7; i++) begin
      aiOne = 16'(smp[i]);
      aiTwo = 16'(smp[i]);
      belowZero = {1'b0, blw[i], blw[i]};
      curMode = {2{cur[i]}};
      cyc(3);
      chk("ai one", 32'(setOne), expv[i]);
      chk("ai two", 32'(setTwo), expv[i]);
    end
    aiOne = 16'h01f4;
    aiTwo = 16'h01f4;
    selOne = 4'h2;
    selTwo = 4'h4;
    cyc(3);
    chk("sel one", 32'(setOne), 5000);
    chk("sel two", 32'(setTwo), 5000);
    selOne = 4'h1;
    filtOne = 10'h001;
    aiOne = 16'h03e8;
    cyc(12);
    rng("filter slow", setOne, 2600, 9000);
    cyc(500);
    chk("filter done", 32'(setOne), 10000);
    pulseHalf = 8'h04;
    cyc(1000);
    rng("pulse count", pFreq, 49, 51);
    rng("pulse setting", setPulse, 4800, 5200);
    tally_and_finish;
  end
endmodule
`default_nettype wire
